// ---- bench/ladder_dac_asserts.sv ----
`timescale 1ns/10ps
module ladder_dac_asserts
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_wake,
  input wire logic [7:0] o_rdata,
  input wire logic o_enable,
  input wire logic [4:0] o_level,
  input wire logic o_pin_analog,
  input wire logic o_pin_read
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  wire logic w0 = i_wr && i_addr == 8'h00;
  wire logic w1 = i_wr && i_addr == 8'h01;
  chk_level_wr: assert property (w1 |=> o_level == $past(i_wdata[4:0]))
    else $error("level");
  chk_enable_wr: assert property (w0 |=> o_enable == $past(i_wdata[7]))
    else $error("enable");
  chk_pin_drive: assert property (w0 |=> o_pin_analog == &($past(i_wdata[7:5]) | 3'h2))
    else $error("pin");
  chk_pin_zero: assert property (o_pin_analog |-> !o_pin_read)
    else $error("pin read");
  chk_read_back: assert property (i_rd && i_addr == 8'h01 |=> o_rdata == {3'h0, o_level})
    else $error("readback");
  chk_unmapped_read: assert property (i_rd && i_addr > 8'h01 |=> o_rdata == 8'h00)
    else $error("unmapped");
  chk_reset_clear: assert property ($past(i_srst) |-> !o_enable && o_level == 5'h00)
    else $error("reset");
  chk_wake_hold: assert property (i_wake && !i_wr |=> $stable(o_enable))
    else $error("wake");
  cover property (o_pin_analog);
  cover property (i_rd ##1 o_rdata != 8'h00);
  cover property ($rose(o_enable));
endmodule

// ---- bench/ladder_reference_dac_control_tb.sv ----
`timescale 1ns/10ps
module ladder_reference_dac_control_tb;
  logic i_mclk = 0, i_srst = 1, i_wr = 0, i_rd = 0, i_wake = 1, i_pin_raw = 1;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic [5:0] o_ladder_ratio_num;
  logic [4:0] o_level;
  logic [2:0] o_high_onehot;
  logic o_enable, o_low_ground, o_to_comparator, o_to_adc, o_pin_analog, o_digital_off;
  logic o_pin_read;
  // first, second, source lines, ratio
  logic [24:0] r, t [4] = '{{8'hA4, 8'h1F, 3'h2, 6'h1F}, {8'h80, 8'h00, 3'h1, 6'h00},
    {8'h88, 8'h10, 3'h4, 6'h10}, {8'hEC, 8'hFF, 3'h0, 6'h1F}};
  int errors = 0, tests_run = 0, cyc = 0;
  ladder_reference_dac_control dut (.*);
  always #20 i_mclk = ~i_mclk;
  task chk(logic [7:0] g, e);
    tests_run++;
    errors += (g !== e);
    if (g !== e) $display("[ERR] %0t bad %h", $time, g);
  endtask
  task acc(logic w, logic [7:0] a, v);
    @(posedge i_mclk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 0;
    i_rd <= 0;
    #1;
  endtask
  task conclude;
    if (cyc > 400) errors++;
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // run needs about 50 cycles
  always @(posedge i_mclk)
    if (++cyc > 400) conclude();
  initial
  begin
    repeat (5) @(posedge i_mclk);
    i_srst <= 0;
    foreach (t[k])
    begin
      r = t[k];
      acc(1, 8'h00, r[24:17]);
      acc(1, 8'h01, r[16:9]);
      chk(o_high_onehot, r[8:6]);
      chk(o_ladder_ratio_num, r[5:0]);
      chk({o_pin_analog, o_digital_off, o_pin_read}, {r[22], r[22], !r[22]});
      chk({o_to_adc, o_to_comparator, o_low_ground}, 8'h07);
      acc(0, 8'h00, 8'h00);
      chk(o_rdata, r[24:17] & 8'hAC);
      acc(0, 8'h01, 8'h00);
      chk(o_rdata, r[16:9] & 8'h1F);
      $display("row %0d done", k);
    end
    acc(0, 8'h02, 8'h00);
    chk(o_rdata, 8'h00);
    // software parks the converter before sleep; pin bit alone must not drive
    acc(1, 8'h00, 8'h24);
    chk({o_enable, o_to_adc, o_to_comparator, o_high_onehot}, 8'h00);
    chk({o_pin_analog, o_digital_off, o_ladder_ratio_num}, 8'h00);
    chk(o_pin_read, 8'h01);
    $display("disable done");
    acc(1, 8'h00, 8'hA4);
    @(posedge i_mclk) i_srst <= 1;
    repeat (5) @(posedge i_mclk);
    i_srst <= 0;
    #1 chk({o_enable, o_pin_analog, o_level}, 8'h00);
    $display("reset done");
    conclude();
  end
endmodule
bind ladder_reference_dac_control ladder_dac_asserts watch (.*);

// ---- hw/ladder_dac_pkg.sv ----
package ladder_dac_pkg;

  typedef enum logic [1:0]
  {
    SRC_SUPPLY = 2'b00,
    SRC_EXT_PIN = 2'b01,
    SRC_FIXED_REF = 2'b10,
    SRC_RESERVED = 2'b11
  } high_source_e;

  typedef logic [4:0] level_t;

endpackage

// ---- hw/ladder_dac_regs.svh ----
`ifndef LADDER_DAC_REGS_SVH
`define LADDER_DAC_REGS_SVH

`define CTRL_FIRST_ADDR 8'h00
`define CTRL_SECOND_ADDR 8'h01
`define ENABLE_BIT 7
`define PIN_DRIVE_BIT 5
`define SRC_SEL_HI 3
`define SRC_SEL_LO 2
`define LEVEL_HI 4
`define LEVEL_LO 0
`define CTRL_FIRST_MASK 8'hAC
`define CTRL_SECOND_MASK 8'h1F
`define CTRL_FIRST_RST 8'h00
`define CTRL_SECOND_RST 8'h00
`define LEVEL_COUNT 32
`define LEVEL_SHIFT 5

`endif

// ---- hw/ladder_pin_ctrl.sv ----
`timescale 1ns/10ps

module ladder_pin_ctrl
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_pin_drive,
  input wire logic i_pin_raw,
  output logic o_pin_analog,
  output logic o_digital_off,
  output logic o_pin_read
);

  logic sync1_ff;
  logic sync2_ff;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= i_pin_raw;
      sync2_ff <= sync1_ff;
    end
  end

  assign o_pin_analog = i_pin_drive;
  assign o_digital_off = i_pin_drive;
  // detector is off, so the read is forced low
  assign o_pin_read = i_pin_drive ? 1'b0 : sync2_ff;

endmodule

// ---- hw/ladder_reference_dac_control.sv ----
`timescale 1ns/10ps
`include "ladder_dac_regs.svh"

module ladder_reference_dac_control
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_wake,
  input wire logic i_pin_raw,
  output logic o_enable,
  output logic [4:0] o_level,
  output logic [5:0] o_ladder_ratio_num,
  output logic [2:0] o_high_onehot,
  output logic o_low_ground,
  output logic o_to_comparator,
  output logic o_to_adc,
  output logic o_pin_analog,
  output logic o_digital_off,
  output logic o_pin_read
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] first_ff;
  logic [7:0] second_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_first;
  logic [7:0] nxt_second;
  logic [7:0] nxt_rdata;

  wire logic hit_first;
  wire logic hit_second;
  wire logic enable_bit;
  wire logic pin_drive;
  wire logic [1:0] src_sel;

  assign hit_first = i_addr == `CTRL_FIRST_ADDR;
  assign hit_second = i_addr == `CTRL_SECOND_ADDR;

  // wake carries no reset: the first register is simply left alone
  assign nxt_first = (i_wr && hit_first) ? (i_wdata & `CTRL_FIRST_MASK) : first_ff;
  assign nxt_second = (i_wr && hit_second) ? (i_wdata & `CTRL_SECOND_MASK) : second_ff;
  // unmapped addresses read zero
  assign nxt_rdata = !i_rd ? 8'h00 :
                     hit_first ? first_ff :
                     hit_second ? second_ff : 8'h00;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      first_ff <= `CTRL_FIRST_RST;
      second_ff <= `CTRL_SECOND_RST;
      rdata_ff <= 8'h00;
    end
    else
    begin
      first_ff <= nxt_first;
      second_ff <= nxt_second;
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // ladder control

  assign enable_bit = first_ff[`ENABLE_BIT];
  assign pin_drive = first_ff[`PIN_DRIVE_BIT] & enable_bit;
  assign src_sel = first_ff[`SRC_SEL_HI:`SRC_SEL_LO];

  assign o_enable = enable_bit;
  assign o_level = second_ff[`LEVEL_HI:`LEVEL_LO];
  // tap fraction is num/2^5; zero when disabled, low source is ground
  assign o_ladder_ratio_num = enable_bit ? {1'b0, o_level} : 6'h00;
  assign o_to_comparator = enable_bit;
  assign o_to_adc = enable_bit;

  ladder_source_route u_route
  (
    .i_enable(enable_bit),
    .i_src_sel(src_sel),
    .o_high_onehot(o_high_onehot),
    .o_low_ground(o_low_ground)
  );

  ladder_pin_ctrl u_pin
  (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_pin_drive(pin_drive),
    .i_pin_raw(i_pin_raw),
    .o_pin_analog(o_pin_analog),
    .o_digital_off(o_digital_off),
    .o_pin_read(o_pin_read)
  );

  // i_wake only matters in that it changes nothing
  wire logic unused_wake;
  assign unused_wake = i_wake;

endmodule

// ---- hw/ladder_source_route.sv ----
`timescale 1ns/10ps
`include "ladder_dac_regs.svh"

module ladder_source_route
(
  input wire logic i_enable,
  input wire logic [1:0] i_src_sel,
  output logic [2:0] o_high_onehot,
  output logic o_low_ground
);

  wire logic sel_supply;
  wire logic sel_ext;
  wire logic sel_fixed;

  // reserved code selects nothing: ladder top left with no source connected
  assign sel_supply = i_src_sel == ladder_dac_pkg::SRC_SUPPLY;
  assign sel_ext = i_src_sel == ladder_dac_pkg::SRC_EXT_PIN;
  assign sel_fixed = i_src_sel == ladder_dac_pkg::SRC_FIXED_REF;
  assign o_high_onehot = i_enable ? {sel_fixed, sel_ext, sel_supply} : 3'h0;
  assign o_low_ground = 1'b1;

endmodule
